/* aic_host_model.sv */
// Host model issuing byte writes and reads on the register strobe port.
`timescale 1ns/1ns
`default_nettype none
module aic_host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata_q,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Idle address (and data after a write) is inverted so a stale byte never looks valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata_q;
   endtask
endmodule
`default_nettype wire

/* aic_pkg.sv */
// Package with register map, field layout and timing constants of the control slice.
package aic_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] AIC_OFS_IRQ_MASK_0 = 8'h33;
   localparam logic [7:0] AIC_OFS_IRQ_LATCHED_STATUS_0 = 8'h36;
   localparam logic [7:0] AIC_OFS_BIAS_FULLSCALE_CONFIG = 8'h3b;
   localparam logic [7:0] AIC_OFS_CHAN1_INPUT_CONFIG = 8'h3c;

   // ==========================================================
   // Reset values
   localparam logic [7:0] AIC_RST_IRQ_MASK_0 = 8'hff;
   localparam logic [7:0] AIC_RST_IRQ_LATCHED_STATUS_0 = 8'h00;
   localparam logic [7:0] AIC_RST_BIAS_FULLSCALE_CONFIG = 8'h00;
   localparam logic [7:0] AIC_RST_CHAN1_INPUT_CONFIG = 8'h00;

   // ==========================================================
   // Field positions
   localparam int AIC_BIT_AUDIO_CLK_ERR = 7;
   localparam int AIC_BIT_PLL_LOCK = 6;
   localparam int AIC_NUM_EVENTS = 2;
   localparam logic [7:0] AIC_EVENT_BITS = 8'hc0;
   localparam int AIC_MIC_BIAS_LSB = 4;
   localparam int AIC_FULLSCALE_LSB = 0;
   localparam int AIC_CH1_KIND_BIT = 7;
   localparam int AIC_CH1_SRC_LSB = 5;
   localparam int AIC_CH1_COUPLING_BIT = 4;
   localparam int AIC_CHAN1_IMPEDANCE_LSB = 2;
   localparam int AIC_CH1_AGC_BIT = 0;

   // Writable bits; everything else is reserved, ignores writes and reads zero.
   localparam logic [7:0] AIC_WMASK_BIAS_FULLSCALE = 8'h73;
   localparam logic [7:0] AIC_WMASK_CHAN1_INPUT = 8'hfd;

   // ==========================================================
   // Interrupt event modes
   typedef enum logic [1:0] {
      AIC_IRQ_LEVEL = 2'b00,
      AIC_IRQ_RSVD = 2'b01,
      AIC_IRQ_REPEAT = 2'b10,
      AIC_IRQ_ONCE = 2'b11
   } aic_irq_mode_e;

   // ==========================================================
   // Timing
   localparam int AIC_CLK_HZ = 10_000_000;
   localparam int AIC_IRQ_PULSE_MS = 2;
   localparam int AIC_IRQ_PERIOD_MS = 4;
   localparam int AIC_IRQ_PULSE_CYC = AIC_IRQ_PULSE_MS * (AIC_CLK_HZ / 1000);
   localparam int AIC_IRQ_PERIOD_CYC = AIC_IRQ_PERIOD_MS * (AIC_CLK_HZ / 1000);
   localparam int AIC_TIMER_W = 16;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [2:0] mic_bias_select;
      logic [1:0] fullscale_select;
   } aic_bias_cfg_s;

   typedef struct packed {
      logic chan1_input_kind;
      logic [1:0] chan1_source_select;
      logic chan1_coupling;
      logic [1:0] chan1_impedance;
      logic chan1_auto_gain_enable;
   } aic_chan1_cfg_s;

   typedef struct packed {
      logic irq_polarity;
      logic [1:0] irq_event_mode;
      logic latched_readback_filter;
   } aic_irq_cfg_s;

endpackage

/* aic_regs.sv */
// Interrupt mask/status, bias/full-scale and channel 1 input configuration registers.
//
// Operation
// - Mask bit 7 blocks clock-error interrupt.
// - Mask bit 6 blocks PLL-lock interrupt.
// - Mask resets all ones; all bits writable.
// - Status bit 7 latches clock error, read-clears.
// - Status bit 6 latches PLL lock, read-clears; bits 5-0 read zero.
// - Bits 6-4 pick microphone bias level.
// - Bits 1-0 pick full-scale reference voltage.
// - Bit 7 picks microphone or line input.
// - Bits 6-5 pick channel 1 source.
// - Bit 4 picks AC or DC coupling.
// - Bits 3-2 pick input impedance.
// - Bit 0 enables channel 1 automatic gain.
// - Readback filter hides masked latched events.
// - Interrupt level, repeating or one-shot pulse.
// - Polarity bit sets interrupt output level.
`timescale 1ns/1ns
`default_nettype none

module aic_regs
   import aic_pkg::*;
#(
   parameter int PULSE_CYC = AIC_IRQ_PULSE_CYC,
   parameter int PERIOD_CYC = AIC_IRQ_PERIOD_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   output logic reg_rvalid_q,
   input wire aic_irq_cfg_s irq_cfg,
   input wire logic audio_clk_err_evt,
   input wire logic pll_lock_evt,
   output logic irq_out_q,
   output aic_bias_cfg_s bias_cfg,
   output aic_chan1_cfg_s chan1_cfg
);

   // ==========================================================
   // Parameter checks
   // Refused at elaboration, since a timer that wraps would stretch or drop pulses.
   if (PULSE_CYC < 1 || PERIOD_CYC <= PULSE_CYC
      || PERIOD_CYC >= (1 << AIC_TIMER_W)) begin : g_bad_timer
      $error("aic_regs: pulse and period counts do not fit the timer");
   end

   localparam logic [AIC_TIMER_W-1:0] PULSE_T = AIC_TIMER_W'(PULSE_CYC);
   localparam logic [AIC_TIMER_W-1:0] PERIOD_T = AIC_TIMER_W'(PERIOD_CYC);

   // ==========================================================
   // Decode
   logic wr_mask, wr_bias, wr_chan1, rd_status;
   assign wr_mask = reg_wr && (reg_addr == AIC_OFS_IRQ_MASK_0);
   assign wr_bias = reg_wr && (reg_addr == AIC_OFS_BIAS_FULLSCALE_CONFIG);
   assign wr_chan1 = reg_wr && (reg_addr == AIC_OFS_CHAN1_INPUT_CONFIG);
   assign rd_status = reg_rd && (reg_addr == AIC_OFS_IRQ_LATCHED_STATUS_0);

   // ==========================================================
   // Mask register
   logic [7:0] irq_mask_0_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_0_q <= AIC_RST_IRQ_MASK_0;
      end else if (wr_mask) begin
         irq_mask_0_q <= reg_wdata;
      end
   end

   // ==========================================================
   // Latched status
   logic [7:0] status_raw;
   logic [7:0] status_view;
   logic [AIC_NUM_EVENTS-1:0] evt_in;
   logic [AIC_NUM_EVENTS-1:0] evt_flag;
   logic [AIC_NUM_EVENTS-1:0] evt_clear;

   assign evt_in = {audio_clk_err_evt, pll_lock_evt};

   // A read clears only the bits it actually shows, so a masked event hidden by
   // the readback filter stays latched until a read with it unmasked or with the filter off.
   assign evt_clear = {AIC_NUM_EVENTS{rd_status}}
      & status_view[AIC_BIT_AUDIO_CLK_ERR -: AIC_NUM_EVENTS];

   genvar gi;
   generate
      for (gi = 0; gi < AIC_NUM_EVENTS; gi++) begin : g_evt
         aic_sticky_bit u_flag (
            .clk(clk),
            .rst(rst),
            .set_pulse(evt_in[gi]),
            .clear_pulse(evt_clear[gi]),
            .flag_q(evt_flag[gi])
         );
      end
   endgenerate

   assign status_raw = {evt_flag, 6'h00};

   always_comb begin
      if (irq_cfg.latched_readback_filter) begin
         status_view = status_raw & ~irq_mask_0_q;
      end else begin
         status_view = status_raw;
      end
   end

   // ==========================================================
   // Bias and channel 1 configuration
   logic [7:0] bias_fullscale_config_q;
   logic [7:0] chan1_input_config_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         bias_fullscale_config_q <= AIC_RST_BIAS_FULLSCALE_CONFIG;
      end else if (wr_bias) begin
         bias_fullscale_config_q <= reg_wdata & AIC_WMASK_BIAS_FULLSCALE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chan1_input_config_q <= AIC_RST_CHAN1_INPUT_CONFIG;
      end else if (wr_chan1) begin
         // The host must set up the general pins before changing the source.
         chan1_input_config_q <= reg_wdata & AIC_WMASK_CHAN1_INPUT;
      end
   end

   // Reserved codes are stored as written; the analog side treats them as its own.
   assign bias_cfg.mic_bias_select = bias_fullscale_config_q[AIC_MIC_BIAS_LSB +: 3];
   assign bias_cfg.fullscale_select = bias_fullscale_config_q[AIC_FULLSCALE_LSB +: 2];
   assign chan1_cfg.chan1_input_kind = chan1_input_config_q[AIC_CH1_KIND_BIT];
   assign chan1_cfg.chan1_source_select = chan1_input_config_q[AIC_CH1_SRC_LSB +: 2];
   assign chan1_cfg.chan1_coupling = chan1_input_config_q[AIC_CH1_COUPLING_BIT];
   assign chan1_cfg.chan1_impedance = chan1_input_config_q[AIC_CHAN1_IMPEDANCE_LSB +: 2];
   assign chan1_cfg.chan1_auto_gain_enable = chan1_input_config_q[AIC_CH1_AGC_BIT];

   // ==========================================================
   // Read port
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            AIC_OFS_IRQ_MASK_0: reg_rdata_q <= irq_mask_0_q;
            AIC_OFS_IRQ_LATCHED_STATUS_0: reg_rdata_q <= status_view;
            AIC_OFS_BIAS_FULLSCALE_CONFIG: reg_rdata_q <= bias_fullscale_config_q;
            AIC_OFS_CHAN1_INPUT_CONFIG: reg_rdata_q <= chan1_input_config_q;
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Interrupt generation
   logic [AIC_NUM_EVENTS-1:0] evt_unmasked;
   logic [AIC_NUM_EVENTS-1:0] new_unmasked;
   logic pending;
   logic new_event;
   aic_irq_mode_e mode;

   assign evt_unmasked = evt_flag & ~irq_mask_0_q[AIC_BIT_AUDIO_CLK_ERR -: AIC_NUM_EVENTS];
   assign new_unmasked = evt_in & ~irq_mask_0_q[AIC_BIT_AUDIO_CLK_ERR -: AIC_NUM_EVENTS];
   assign pending = |evt_unmasked;
   assign new_event = |new_unmasked;
   assign mode = aic_irq_mode_e'(irq_cfg.irq_event_mode);

   // Repeat timer: free runs over the whole period while an event is pending.
   logic [AIC_TIMER_W-1:0] rep_cnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         rep_cnt_q <= '0;
      end else if (!pending || mode != AIC_IRQ_REPEAT) begin
         rep_cnt_q <= '0;
      end else if (rep_cnt_q == PERIOD_T - 1'b1) begin
         rep_cnt_q <= '0;
      end else begin
         rep_cnt_q <= rep_cnt_q + 1'b1;
      end
   end

   // One-shot timer: reloads on every new unmasked event.
   logic [AIC_TIMER_W-1:0] shot_cnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         shot_cnt_q <= '0;
      end else if (mode != AIC_IRQ_ONCE) begin
         shot_cnt_q <= '0;
      end else if (new_event) begin
         shot_cnt_q <= PULSE_T;
      end else if (shot_cnt_q != '0) begin
         shot_cnt_q <= shot_cnt_q - 1'b1;
      end
   end

   logic irq_active;

   always_comb begin
      unique case (mode)
         AIC_IRQ_LEVEL: irq_active = pending;
         AIC_IRQ_RSVD: irq_active = 1'b0;
         AIC_IRQ_REPEAT: irq_active = pending && (rep_cnt_q < PULSE_T);
         AIC_IRQ_ONCE: irq_active = (shot_cnt_q != '0);
      endcase
   end

   // Reset drives the idle level of the default active-low polarity.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_out_q <= 1'b1;
      end else begin
         irq_out_q <= irq_cfg.irq_polarity ? irq_active : ~irq_active;
      end
   end

endmodule
`default_nettype wire

/* aic_regs_monitor.sv */
// Port-level assertions for the control register slice.
`timescale 1ns/1ns
`default_nettype none
module aic_regs_monitor
   import aic_pkg::*;
#(
   parameter int PULSE_CYC = AIC_IRQ_PULSE_CYC,
   parameter int PERIOD_CYC = AIC_IRQ_PERIOD_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic reg_rvalid_q,
   input wire aic_irq_cfg_s irq_cfg,
   input wire logic audio_clk_err_evt,
   input wire logic pll_lock_evt,
   input wire logic irq_out_q,
   input wire aic_bias_cfg_s bias_cfg,
   input wire aic_chan1_cfg_s chan1_cfg
);
   // The mask is shadowed from the strobes, since no port shows it directly.
   logic [7:0] mask_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= 8'hff;
      end else if (reg_wr && reg_addr == 8'h33) begin
         mask_q <= reg_wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd_stat;
      reg_rd && reg_addr == 8'h36 && !irq_cfg.latched_readback_filter;
   endsequence
   sequence s_lvl_quiet;
      irq_cfg.irq_event_mode == 2'd0 && !reg_wr ##1 $stable(irq_cfg) && !reg_wr;
   endsequence
   property p_rvalid;
      reg_rd ##1 !reg_rd |-> reg_rvalid_q ##1 !reg_rvalid_q;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid timing");
   property p_bias_wr;
      reg_wr && reg_addr == 8'h3b |=> {1'b0, bias_cfg[4:2], 2'b00, bias_cfg[1:0]}
         == ($past(reg_wdata) & 8'h73);
   endproperty
   a_bias_wr: assert property (p_bias_wr) else $error("bias write");
   property p_chan1_wr;
      reg_wr && reg_addr == 8'h3c |=> {chan1_cfg[6:1], 1'b0, chan1_cfg[0]}
         == ($past(reg_wdata) & 8'hfd);
   endproperty
   a_chan1_wr: assert property (p_chan1_wr) else $error("chan1 write");
   property p_stat_rsvd;
      reg_rd && reg_addr == 8'h36 |=> reg_rdata_q[5:0] == 6'h00;
   endproperty
   a_stat_rsvd: assert property (p_stat_rsvd) else $error("status low bits");
   property p_clk_latch;
      audio_clk_err_evt ##1 s_rd_stat |=> reg_rdata_q[7];
   endproperty
   a_clk_latch: assert property (p_clk_latch) else $error("clock error not latched");
   property p_irq_raise;
      (audio_clk_err_evt && !mask_q[7]) ##0 s_lvl_quiet
         |=> irq_out_q == $past(irq_cfg.irq_polarity);
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
   property p_masked;
      irq_cfg.irq_event_mode == 2'd1 || irq_cfg.irq_event_mode == 2'd0 && mask_q[7:6] == 2'b11
         |=> irq_out_q == !$past(irq_cfg.irq_polarity);
   endproperty
   a_masked: assert property (p_masked) else $error("irq active while masked");
   property p_clear_irq;
      s_rd_stat ##0 (!audio_clk_err_evt && !pll_lock_evt) ##0 s_lvl_quiet
         |=> irq_out_q == !$past(irq_cfg.irq_polarity);
   endproperty
   a_clear_irq: assert property (p_clear_irq) else $error("irq stuck after read");
endmodule
bind aic_regs aic_regs_monitor #(
   .PULSE_CYC(PULSE_CYC),
   .PERIOD_CYC(PERIOD_CYC)
) u_aic_regs_monitor (
   .clk(clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata_q(reg_rdata_q),
   .reg_rvalid_q(reg_rvalid_q),
   .irq_cfg(irq_cfg),
   .audio_clk_err_evt(audio_clk_err_evt),
   .pll_lock_evt(pll_lock_evt),
   .irq_out_q(irq_out_q),
   .bias_cfg(bias_cfg),
   .chan1_cfg(chan1_cfg)
);
`default_nettype wire

/* aic_regs_tb_top.sv */
// Self-checking testbench for the control register slice.
`timescale 1ns/1ns
`default_nettype none
module aic_regs_tb_top;
   import aic_pkg::*;
   localparam int PULSE_CYC = 4;
   localparam int PERIOD_CYC = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
   logic reg_wr, reg_rd, reg_rvalid_q, irq_out_q;
   logic audio_clk_err_evt = 1'b0;
   logic pll_lock_evt = 1'b0;
   aic_irq_cfg_s irq_cfg = '0;
   aic_bias_cfg_s bias_cfg;
   aic_chan1_cfg_s chan1_cfg;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   int c;
   always #50 clk = ~clk;
   aic_regs #(
      .PULSE_CYC(PULSE_CYC),
      .PERIOD_CYC(PERIOD_CYC)
   ) u_aic_regs (
      .clk(clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q),
      .irq_cfg(irq_cfg),
      .audio_clk_err_evt(audio_clk_err_evt),
      .pll_lock_evt(pll_lock_evt),
      .irq_out_q(irq_out_q),
      .bias_cfg(bias_cfg),
      .chan1_cfg(chan1_cfg)
   );
   aic_host_model u_aic_host_model (
      .clk(clk),
      .reg_rdata_q(reg_rdata_q),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd)
   );
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_aic_host_model.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
      chk("rvalid", 8'h01, {7'h0, reg_rvalid_q});
   endtask
   // Events last exactly one cycle, dropped at the next falling edge.
   task automatic pulse(input logic [1:0] v);
      {audio_clk_err_evt, pll_lock_evt} = v;
      {audio_clk_err_evt, pll_lock_evt} <= #100 2'b00;
   endtask
   task automatic cnt(input int n, input logic [7:0] e);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         c += int'(irq_out_q === irq_cfg.irq_polarity);
      end
      chk("irq count", e, c[7:0]);
   endtask
   task automatic close_out();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      rchk(8'h33, 8'hff);
      rchk(8'h3b, 8'h00);
      rchk(8'h3c, 8'h00);
      u_aic_host_model.wr(8'h36, 8'hff);
      rchk(8'h36, 8'h00);
      rchk(8'h34, 8'h00);
      for (int i = 0; i < 8; i++) begin
         u_aic_host_model.wr(8'h3b, {1'b1, i[2:0], 2'b11, i[1:0]});
         rchk(8'h3b, {1'b0, i[2:0], 2'b00, i[1:0]});
         chk("bias_cfg", {3'h0, i[2:0], i[1:0]}, {3'h0, bias_cfg});
         u_aic_host_model.wr(8'h3c, {i[0], i[1:0], i[1], i[1:0], 1'b1, i[2]});
         rchk(8'h3c, {i[0], i[1:0], i[1], i[1:0], 1'b0, i[2]});
         chk("chan1_cfg", {1'b0, i[0], i[1:0], i[1], i[1:0], i[2]},
            {1'b0, chan1_cfg});
      end
      u_aic_host_model.wr(8'h33, 8'h00);
      rchk(8'h33, 8'h00);
      for (int k = 0; k < 2; k++) begin
         irq_cfg.irq_polarity = k[0];
         pulse({~k[0], k[0]});
         repeat (2) @(negedge clk);
         chk("irq", {7'h0, k[0]}, {7'h0, irq_out_q});
         rchk(8'h36, {~k[0], k[0], 6'h00});
         repeat (2) @(negedge clk);
         chk("irq", {7'h0, ~k[0]}, {7'h0, irq_out_q});
         pulse({~k[0], k[0]});
         rchk(8'h36, {~k[0], k[0], 6'h00});
      end
      u_aic_host_model.wr(8'h33, 8'hff);
      pulse(2'b11);
      repeat (3) @(negedge clk);
      chk("irq", 8'h00, {7'h0, irq_out_q});
      irq_cfg.latched_readback_filter = 1'b1;
      u_aic_host_model.wr(8'h33, 8'h7f);
      repeat (2) @(negedge clk);
      chk("irq", 8'h01, {7'h0, irq_out_q});
      rchk(8'h36, 8'h80);
      irq_cfg.latched_readback_filter = 1'b0;
      rchk(8'h36, 8'h40);
      u_aic_host_model.wr(8'h33, 8'h3f);
      irq_cfg.irq_event_mode = 2'd3;
      pulse(2'b10);
      cnt(12, 8'(PULSE_CYC));
      irq_cfg.irq_event_mode = 2'd2;
      repeat (2) @(negedge clk);
      cnt(2 * PERIOD_CYC, 8'(2 * PULSE_CYC));
      irq_cfg.irq_event_mode = 2'd1;
      cnt(10, 8'h00);
      irq_cfg.irq_event_mode = 2'd0;
      rchk(8'h36, 8'h80);
      close_out();
   end
endmodule
`default_nettype wire

/* aic_sticky_bit.sv */
// One latched event flag: set by hardware, cleared by a status read.
`timescale 1ns/1ns
`default_nettype none

module aic_sticky_bit
   import aic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic set_pulse,
   input wire logic clear_pulse,
   output logic flag_q
);

   // ==========================================================
   // Flag
   // A set in the clearing cycle wins so that no event is lost.
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (set_pulse) begin
         flag_q <= 1'b1;
      end else if (clear_pulse) begin
         flag_q <= 1'b0;
      end
   end

endmodule
`default_nettype wire
